// *** rtl/core_state.sv ***
`timescale 1ns/1ps
module core_state (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset_n,
  // program flow
  input  wire logic                       pc_load,
  input  wire logic [15:0]                pc_value,
  input  wire logic [1:0]                 pc_step,
  input  wire logic                       irq_take,
  input  wire logic [2:0]                 irq_index,
  output logic      [15:0]                code_addr,
  // alu and flag events
  input  wire core_state_pkg::alu_req_t   alu_req,
  input  wire logic                       carry_we,
  input  wire logic                       carry_in,
  input  wire logic                       clear_range,
  input  wire logic                       bit_test,
  input  wire logic [7:0]                 bit_test_data,
  input  wire logic                       acc_we,
  input  wire logic [7:0]                 acc_wdata,
  input  wire logic                       data_ptr_inc,
  input  wire logic                       push,
  input  wire logic [7:0]                 push_data,
  // operand address resolution
  input  wire core_state_pkg::addr_mode_t res_mode,
  input  wire logic [7:0]                 res_field,
  output core_state_pkg::addr_res_t       res_out,
  // data access
  input  wire logic                       mem_we,
  input  wire logic                       mem_re,
  input  wire core_state_pkg::space_t     mem_space,
  input  wire logic [15:0]                mem_addr,
  input  wire logic [7:0]                 mem_wdata,
  output logic      [7:0]                 mem_rdata,
  output logic                            ddc_hit,
  // architectural state view
  output logic      [7:0]                 flags_out,
  output logic      [15:0]                data_ptr_out,
  output logic      [7:0]                 sp_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic [7:0]  psw_reg;
  logic [7:0]  psw_next;
  logic [7:0]  acc_reg;
  logic [7:0]  acc_next;
  logic [7:0]  sp_reg;
  logic [7:0]  ptr_hi_reg;
  logic [7:0]  ptr_lo_reg;
  logic [15:0] data_ptr_next;
  logic [7:0]  ddc_ptr_reg;
  logic [7:0]  ddc_ptr_next;
  logic [7:0]  ddc_ctl_reg;
  logic        first_reg;
  logic [7:0]  iram [256];
  logic [7:0]  ddc_ram [256];
  core_state_pkg::addr_res_t res_next;

  // bit address to byte address: low half is the bit RAM, upper half the
  // bit-addressable registers on 8-byte boundaries
  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    bit_byte = b[7] ? {b[7:3], 3'h0} : core_state_pkg::BIT_RAM + {4'h0, b[6:3]};
  endfunction

  // ---------------------------------------------------------------
  // alu flag generation
  // ---------------------------------------------------------------
  wire [8:0] alu_sum  = {1'b0, alu_req.a} + {1'b0, alu_req.b} + {8'h00, alu_req.cin};
  wire [8:0] alu_dif  = {1'b0, alu_req.a} - {1'b0, alu_req.b} - {8'h00, alu_req.cin};
  wire [4:0] nib_sum  = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]} + {4'h0, alu_req.cin};
  wire [4:0] nib_dif  = {1'b0, alu_req.a[3:0]} - {1'b0, alu_req.b[3:0]} - {4'h0, alu_req.cin};
  wire [7:0] alu_res  = alu_req.sub ? alu_dif[7:0] : alu_sum[7:0];
  wire       alu_carry = alu_req.sub ? ~alu_dif[8] : alu_sum[8];
  wire       alu_nib   = alu_req.sub ? ~nib_dif[4] : nib_sum[4];
  wire       b_eff     = alu_req.sub ? ~alu_req.b[7] : alu_req.b[7];
  wire       alu_range = (alu_req.a[7] == b_eff) && (alu_res[7] != alu_req.a[7]);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire [1:0]  bank     = {psw_reg[core_state_pkg::PSW_BANK_HI], psw_reg[core_state_pkg::PSW_BANK_LO]};
  wire [15:0] data_ptr = {ptr_hi_reg, ptr_lo_reg};
  wire        sfr_we   = mem_we && (mem_space == core_state_pkg::SPACE_SFR);
  wire        iram_we  = mem_we && (mem_space == core_state_pkg::SPACE_IRAM);
  wire        sfr_sel  = mem_addr[7] && (mem_space == core_state_pkg::SPACE_SFR);
  wire [7:0]  sfr_a    = mem_addr[7:0];
  wire        acc_wr   = sfr_we && (sfr_a == core_state_pkg::SFR_ACC);
  wire        hi_wr    = sfr_we && (sfr_a == core_state_pkg::SFR_PTR_HI);
  wire        lo_wr    = sfr_we && (sfr_a == core_state_pkg::SFR_PTR_LO);
  wire        ddc_wr   = sfr_we && (sfr_a == core_state_pkg::SFR_DDC_PTR);
  wire        win_acc  = sfr_sel && (sfr_a == core_state_pkg::SFR_DDC_WIN) && (mem_we || mem_re);
  wire        ddc_en   = ddc_ctl_reg[core_state_pkg::DDC_EN_BIT];
  wire        x_sel    = mem_space == core_state_pkg::SPACE_XDATA;
  wire        ddc_sel  = x_sel && ddc_en && (mem_addr[15:8] == core_state_pkg::DDC_PAGE);
  wire [7:0]  sp_inc   = sp_reg + 8'h01;
  wire [7:0]  reg_ptr  = {3'h0, bank, 2'h0, res_field[0]};
  wire [15:0] vec_addr = core_state_pkg::VEC_BASE + {10'h000, irq_index, 3'h0};
  wire        parity   = ^acc_reg;

  // flags with the live parity folded in
  wire [7:0] psw_view  = {psw_reg[7:1], parity};

  assign flags_out = psw_view;
  assign data_ptr_out = data_ptr;
  assign sp_out    = sp_reg;
  assign code_addr = pc_reg;
  assign ddc_hit   = ddc_sel;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  assign pc_next = irq_take ? vec_addr : pc_load ? pc_value : pc_reg + {14'h0000, pc_step};

  // hardware flag events override a same-cycle software write
  always_comb
  begin
    psw_next = psw_reg;
    if (sfr_we && sfr_a == core_state_pkg::SFR_PSW)
      psw_next = mem_wdata;
    if (clear_range)
      psw_next[core_state_pkg::PSW_RANGE] = 1'b0;
    if (bit_test)
      psw_next[core_state_pkg::PSW_RANGE] = bit_test_data[6];
    if (carry_we)
      psw_next[core_state_pkg::PSW_CARRY] = carry_in;
    if (alu_req.valid)
    begin
      psw_next[core_state_pkg::PSW_CARRY] = alu_carry;
      psw_next[core_state_pkg::PSW_NIB]   = alu_nib;
      psw_next[core_state_pkg::PSW_RANGE] = alu_range;
    end
    psw_next[core_state_pkg::PSW_P] = 1'b0;
  end

  assign acc_next      = alu_req.valid ? alu_res : acc_we ? acc_wdata : acc_wr ? mem_wdata : acc_reg;
  // an increment and a byte write in one cycle: the increment wins
  assign data_ptr_next = data_ptr_inc ? data_ptr + 16'h0001
                                      : {hi_wr ? mem_wdata : ptr_hi_reg, lo_wr ? mem_wdata : ptr_lo_reg};
  assign ddc_ptr_next  = win_acc ? ddc_ptr_reg + 8'h01 : ddc_wr ? mem_wdata : ddc_ptr_reg;

  // operand address resolution
  always_comb
  begin
    res_next = '{space: core_state_pkg::SPACE_IRAM, addr: 16'h0000, bit_pos: 3'h0};
    unique case (res_mode)
      core_state_pkg::MODE_DIRECT:
      begin
        res_next.space = res_field[7] ? core_state_pkg::SPACE_SFR : core_state_pkg::SPACE_IRAM;
        res_next.addr  = {8'h00, res_field};
      end
      core_state_pkg::MODE_INDIRECT:
        // indirect never reaches the register window: upper bytes are RAM
        res_next.addr = {8'h00, res_field[1] ? sp_reg : iram[reg_ptr]};
      core_state_pkg::MODE_IND16:
      begin
        res_next.space = core_state_pkg::SPACE_XDATA;
        res_next.addr  = data_ptr;
      end
      core_state_pkg::MODE_REGISTER:
        res_next.addr = {11'h000, bank, res_field[2:0]};
      core_state_pkg::MODE_SPECIFIC:
      begin
        res_next.space = core_state_pkg::SPACE_SFR;
        res_next.addr  = {8'h00, res_field[0] ? core_state_pkg::SFR_PTR_LO : core_state_pkg::SFR_ACC};
      end
      core_state_pkg::MODE_IMMED:
      begin
        res_next.space = core_state_pkg::SPACE_CODE;
        res_next.addr  = pc_reg + {14'h0000, res_field[1:0]};
      end
      core_state_pkg::MODE_INDEXED:
      begin
        res_next.space = core_state_pkg::SPACE_CODE;
        res_next.addr  = (res_field[0] ? pc_reg : data_ptr) + {8'h00, acc_reg};
      end
      core_state_pkg::MODE_BIT:
      begin
        res_next.space   = res_field[7] ? core_state_pkg::SPACE_SFR : core_state_pkg::SPACE_IRAM;
        res_next.addr    = {8'h00, bit_byte(res_field)};
        res_next.bit_pos = res_field[2:0];
      end
      default:
        res_next.space = core_state_pkg::SPACE_IRAM;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_reg      <= core_state_pkg::PC_RESET;
      psw_reg     <= core_state_pkg::PSW_RESET;
      acc_reg     <= core_state_pkg::BYTE_RESET;
      sp_reg      <= core_state_pkg::SP_RESET;
      {ptr_hi_reg, ptr_lo_reg} <= {core_state_pkg::BYTE_RESET, core_state_pkg::BYTE_RESET};
      ddc_ptr_reg <= core_state_pkg::BYTE_RESET;
      ddc_ctl_reg <= core_state_pkg::BYTE_RESET;
      first_reg   <= 1'b1;
      res_out     <= '0;
    end
    else
    begin
      pc_reg      <= pc_next;
      psw_reg     <= psw_next;
      acc_reg     <= acc_next;
      sp_reg      <= push ? sp_inc : (sfr_we && sfr_a == core_state_pkg::SFR_SP) ? mem_wdata : sp_reg;
      {ptr_hi_reg, ptr_lo_reg} <= data_ptr_next;
      ddc_ptr_reg <= ddc_ptr_next;
      ddc_ctl_reg <= (sfr_we && sfr_a == core_state_pkg::SFR_DDC_CTL) ? mem_wdata : ddc_ctl_reg;
      first_reg   <= 1'b0;
      res_out     <= res_next;
    end
  end

  // memories carry no reset; push wins over a same-cycle internal RAM write
  always_ff @(posedge clk_sys)
  begin
    if (push)
      iram[sp_inc] <= push_data;
    else if (iram_we)
      iram[mem_addr[7:0]] <= mem_wdata;
    if (ddc_sel && mem_we)
      ddc_ram[mem_addr[7:0]] <= mem_wdata;
    else if (win_acc && mem_we)
      ddc_ram[ddc_ptr_reg] <= mem_wdata;
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [7:0] rd_next;
  always_comb
  begin
    rd_next = 8'h00;
    unique case (mem_space)
      core_state_pkg::SPACE_IRAM:  rd_next = iram[mem_addr[7:0]];
      core_state_pkg::SPACE_XDATA: rd_next = ddc_sel ? ddc_ram[mem_addr[7:0]] : 8'h00;
      core_state_pkg::SPACE_CODE:  rd_next = 8'h00;
      core_state_pkg::SPACE_SFR:
        unique case (sfr_a)
          core_state_pkg::SFR_SP:      rd_next = sp_reg;
          core_state_pkg::SFR_PTR_LO:  rd_next = ptr_lo_reg;
          core_state_pkg::SFR_PTR_HI:  rd_next = ptr_hi_reg;
          core_state_pkg::SFR_PSW:     rd_next = psw_view;
          core_state_pkg::SFR_ACC:     rd_next = acc_reg;
          core_state_pkg::SFR_DDC_PTR: rd_next = ddc_ptr_reg;
          core_state_pkg::SFR_DDC_WIN: rd_next = ddc_ram[ddc_ptr_reg];
          core_state_pkg::SFR_DDC_CTL: rd_next = ddc_ctl_reg;
          default:                     rd_next = 8'h00;
        endcase
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      mem_rdata <= core_state_pkg::BYTE_RESET;
    else
      mem_rdata <= rd_next;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_FIRST_FETCH: assert property (first_reg |-> code_addr == 16'h0000)
    else $error("first fetch not at zero");
  AST_VECTOR: assert property (irq_take |=> code_addr == 16'h0003 + 16'h0008 * $past(irq_index))
    else $error("wrong interrupt vector");
  AST_BANK: assert property (res_mode == core_state_pkg::MODE_REGISTER |=>
    res_out.addr == {11'h000, $past(bank), $past(res_field[2:0])})
    else $error("register bank address wrong");
  AST_CARRY_ADD: assert property (alu_req.valid && !alu_req.sub |=>
    flags_out[7] == ($past({1'b0, alu_req.a}) + $past({1'b0, alu_req.b}) + $past(alu_req.cin) > 9'h0ff))
    else $error("carry after add wrong");
  AST_RANGE_CLEAR: assert property (clear_range && !alu_req.valid && !bit_test |=> !flags_out[2])
    else $error("range flag not cleared");
  AST_RANGE_BIT: assert property (bit_test && !alu_req.valid |=> flags_out[2] == $past(bit_test_data[6]))
    else $error("bit test copy wrong");
  AST_PARITY: assert property (acc_we && !alu_req.valid |=> flags_out[0] == ^$past(acc_wdata))
    else $error("parity flag wrong");
  AST_PUSH: assert property (push |=> sp_out == $past(sp_out) + 8'h01)
    else $error("stack pointer not pre-incremented");
  AST_DDC_INC: assert property (win_acc |=> ddc_ptr_reg == $past(ddc_ptr_reg) + 8'h01)
    else $error("ddc pointer did not advance");
  AST_DIRECT: assert property (res_mode == core_state_pkg::MODE_DIRECT && res_field[7] |=>
    res_out.space == core_state_pkg::SPACE_SFR)
    else $error("direct high address not in sfr space");
  AST_BITMAP: assert property (res_mode == core_state_pkg::MODE_BIT && !res_field[7] |=>
    res_out.addr[7:0] == 8'h20 + ($past(res_field) >> 3))
    else $error("bit byte mapping wrong");
  AST_IDX: assert property (res_mode == core_state_pkg::MODE_INDEXED && !res_field[0] |=>
    res_out.addr == $past(data_ptr) + $past({8'h00, acc_reg}))
    else $error("indexed address wrong");

  COV_IRQ:  cover property (irq_take ##1 push ##1 push);
  COV_DDC:  cover property (win_acc ##1 win_acc ##1 win_acc);
  COV_OVF:  cover property (alu_req.valid && alu_range ##1 clear_range);

endmodule

// *** rtl/core_state_pkg.sv ***
package core_state_pkg;

  // ---------------------------------------------------------------
  // reset values and vectors
  // ---------------------------------------------------------------
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [15:0] VEC_BASE   = 16'h0003;
  localparam logic [15:0] VEC_STEP   = 16'h0008;
  localparam logic [7:0]  SP_RESET   = 8'h07;
  localparam logic [7:0]  PSW_RESET  = 8'h00;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [7:0] SFR_BASE    = 8'h80;
  localparam logic [7:0] BIT_RAM     = 8'h20;
  localparam logic [7:0] DDC_PAGE    = 8'hff;
  localparam logic [7:0] SFR_SP      = 8'h81;
  localparam logic [7:0] SFR_PTR_LO  = 8'h82;
  localparam logic [7:0] SFR_PTR_HI  = 8'h83;
  localparam logic [7:0] SFR_DDC_PTR = 8'h94;
  localparam logic [7:0] SFR_DDC_WIN = 8'h95;
  localparam logic [7:0] SFR_DDC_CTL = 8'h96;
  localparam logic [7:0] SFR_PSW     = 8'hd0;
  localparam logic [7:0] SFR_ACC     = 8'he0;
  localparam int         DDC_EN_BIT  = 0;

  // ---------------------------------------------------------------
  // status word fields
  // ---------------------------------------------------------------
  localparam int PSW_CARRY   = 7;
  localparam int PSW_NIB     = 6;
  localparam int PSW_F0      = 5;
  localparam int PSW_BANK_HI = 4;
  localparam int PSW_BANK_LO = 3;
  localparam int PSW_RANGE   = 2;
  localparam int PSW_P       = 0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    MODE_DIRECT   = 8'h01,
    MODE_INDIRECT = 8'h02,
    MODE_IND16    = 8'h04,
    MODE_REGISTER = 8'h08,
    MODE_SPECIFIC = 8'h10,
    MODE_IMMED    = 8'h20,
    MODE_INDEXED  = 8'h40,
    MODE_BIT      = 8'h80
  } addr_mode_t;

  typedef enum logic [1:0] {
    SPACE_IRAM  = 2'h0,
    SPACE_SFR   = 2'h1,
    SPACE_CODE  = 2'h2,
    SPACE_XDATA = 2'h3
  } space_t;

  typedef struct packed {
    logic       valid;
    logic       sub;
    logic       cin;
    logic [7:0] a;
    logic [7:0] b;
  } alu_req_t;

  typedef struct packed {
    space_t      space;
    logic [15:0] addr;
    logic [2:0]  bit_pos;
  } addr_res_t;

endpackage

// *** testbench/prog_rom.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// program memory model
// ---------------------------------------------------------------
// a fixed pattern stands in for code bytes; it changes with every low
// address byte, so a stale fetch address cannot go unnoticed
module prog_rom (
  // clock
  input  wire logic        clk_sys,
  // fetch side
  input  wire logic [15:0] code_addr,
  output logic      [7:0]  code_data
);
  always_ff @(posedge clk_sys)
  begin
    code_data <= code_addr[7:0] ^ 8'h5a;
  end
endmodule

// *** testbench/cpu_core_state_and_addressing_test.sv ***
`timescale 1ns/1ps
module cpu_core_state_and_addressing_test;
  logic clk_sys = 1'b0, reset_n = 1'b0, pc_load = 1'b0, irq_take = 1'b0, carry_we = 1'b0, carry_in = 1'b0;
  logic clear_range = 1'b0, bit_test = 1'b0, acc_we = 1'b0, data_ptr_inc = 1'b0, push = 1'b0, mem_we = 1'b0;
  logic mem_re = 1'b0, ddc_hit;
  logic [15:0] pc_value = 16'h0000, mem_addr = 16'h0000, code_addr, data_ptr_out;
  logic [1:0]  pc_step = 2'h0;
  logic [2:0]  irq_index = 3'h0;
  logic [7:0]  bit_test_data = 8'h00, acc_wdata = 8'h00, push_data = 8'h00, res_field = 8'h00;
  logic [7:0]  mem_wdata = 8'h00, mem_rdata, flags_out, sp_out, code_data;
  core_state_pkg::alu_req_t   alu_req = '0;
  core_state_pkg::addr_mode_t res_mode = core_state_pkg::MODE_DIRECT;
  core_state_pkg::space_t     mem_space = core_state_pkg::SPACE_IRAM;
  core_state_pkg::addr_res_t  res_out;
  int errors = 0, total_checks = 0, cycles = 0;

  always #20 clk_sys = ~clk_sys;

  core_state core_state_inst (.clk_sys(clk_sys), .reset_n(reset_n), .pc_load(pc_load), .pc_value(pc_value),
    .pc_step(pc_step), .irq_take(irq_take), .irq_index(irq_index), .code_addr(code_addr), .alu_req(alu_req),
    .carry_we(carry_we), .carry_in(carry_in), .clear_range(clear_range), .bit_test(bit_test),
    .bit_test_data(bit_test_data), .acc_we(acc_we), .acc_wdata(acc_wdata), .data_ptr_inc(data_ptr_inc),
    .push(push),
    .push_data(push_data), .res_mode(res_mode), .res_field(res_field), .res_out(res_out), .mem_we(mem_we),
    .mem_re(mem_re), .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .ddc_hit(ddc_hit), .flags_out(flags_out), .data_ptr_out(data_ptr_out), .sp_out(sp_out));
  prog_rom prog_rom_inst (.clk_sys(clk_sys), .code_addr(code_addr), .code_data(code_data));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input core_state_pkg::space_t s, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    mem_we <= 1'b1; mem_space <= s; mem_addr <= a; mem_wdata <= d;
    @(posedge clk_sys);
    mem_we <= 1'b0;
  endtask

  task automatic rd(input core_state_pkg::space_t s, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    mem_re <= 1'b1; mem_space <= s; mem_addr <= a;
    @(posedge clk_sys);
    mem_re <= 1'b0;
    #1 chk({8'h00, mem_rdata}, {8'h00, exp});
  endtask

  task automatic res(input core_state_pkg::addr_mode_t m, input logic [7:0] f,
                     input core_state_pkg::space_t s, input logic [15:0] a);
    @(posedge clk_sys);
    res_mode <= m; res_field <= f;
    @(posedge clk_sys);
    #1 chk(res_out.addr, a);
    chk({14'h0, res_out.space}, {14'h0, s});
  endtask

  task automatic alu(input logic s, input logic [7:0] a, input logic [7:0] b, input logic [7:0] flags_exp);
    @(posedge clk_sys);
    alu_req <= '{valid: 1'b1, sub: s, cin: 1'b0, a: a, b: b};
    @(posedge clk_sys);
    alu_req <= '0;
    #1 chk({8'h00, flags_out}, {8'h00, flags_exp});
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1 chk(code_addr, 16'h0000);
    chk({8'h00, sp_out}, 16'h0007);
    chk({8'h00, flags_out}, 16'h0000);
    chk(data_ptr_out, 16'h0000);
    @(posedge clk_sys);
    pc_step <= 2'h1;
    repeat (3) @(posedge clk_sys);
    pc_step <= 2'h0;
    #1 chk(code_addr, 16'h0003);
    @(posedge clk_sys);
    pc_load <= 1'b1; pc_value <= 16'h1234;
    @(posedge clk_sys);
    pc_load <= 1'b0;
    #1 chk(code_addr, 16'h1234);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      irq_take <= 1'b1; irq_index <= 3'(i);
      @(posedge clk_sys);
      irq_take <= 1'b0;
      #1 chk(code_addr, 16'h0003 + 16'(8 * i));
    end
    // bank 2 selected; register, bit, direct and specific resolution
    wr(core_state_pkg::SPACE_SFR, 16'h00d0, 8'h10);
    #1 chk({8'h00, flags_out}, 16'h0010);
    res(core_state_pkg::MODE_REGISTER, 8'h05, core_state_pkg::SPACE_IRAM, 16'h0015);
    res(core_state_pkg::MODE_BIT, 8'h0a, core_state_pkg::SPACE_IRAM, 16'h0021);
    chk({13'h0, res_out.bit_pos}, 16'h0002);
    res(core_state_pkg::MODE_BIT, 8'h83, core_state_pkg::SPACE_SFR, 16'h0080);
    chk({13'h0, res_out.bit_pos}, 16'h0003);
    res(core_state_pkg::MODE_DIRECT, 8'h3e, core_state_pkg::SPACE_IRAM, 16'h003e);
    res(core_state_pkg::MODE_DIRECT, 8'h90, core_state_pkg::SPACE_SFR, 16'h0090);
    res(core_state_pkg::MODE_SPECIFIC, 8'h01, core_state_pkg::SPACE_SFR, 16'h0082);
    res(core_state_pkg::MODE_SPECIFIC, 8'h00, core_state_pkg::SPACE_SFR, 16'h00e0);
    // stack and indirect through bank reg zero and the stack pointer
    @(posedge clk_sys);
    push <= 1'b1; push_data <= 8'h77;
    @(posedge clk_sys);
    push <= 1'b0;
    #1 chk({8'h00, sp_out}, 16'h0008);
    rd(core_state_pkg::SPACE_IRAM, 16'h0008, 8'h77);
    wr(core_state_pkg::SPACE_IRAM, 16'h0010, 8'h33);
    res(core_state_pkg::MODE_INDIRECT, 8'h00, core_state_pkg::SPACE_IRAM, 16'h0033);
    res(core_state_pkg::MODE_INDIRECT, 8'h02, core_state_pkg::SPACE_IRAM, 16'h0008);
    // data pointer bytes, increment and indexed code read
    wr(core_state_pkg::SPACE_SFR, 16'h0082, 8'h10);
    wr(core_state_pkg::SPACE_SFR, 16'h0083, 8'h20);
    #1 chk(data_ptr_out, 16'h2010);
    @(posedge clk_sys);
    data_ptr_inc <= 1'b1; acc_we <= 1'b1; acc_wdata <= 8'h05;
    @(posedge clk_sys);
    data_ptr_inc <= 1'b0; acc_we <= 1'b0;
    #1 chk(data_ptr_out, 16'h2011);
    res(core_state_pkg::MODE_INDEXED, 8'h00, core_state_pkg::SPACE_CODE, 16'h2016);
    res(core_state_pkg::MODE_INDEXED, 8'h01, core_state_pkg::SPACE_CODE, 16'h0040);
    res(core_state_pkg::MODE_IMMED, 8'h01, core_state_pkg::SPACE_CODE, 16'h003c);
    // accumulator loaded from the fetched code byte at 003bh
    @(posedge clk_sys);
    acc_we <= 1'b1; acc_wdata <= code_data;
    @(posedge clk_sys);
    acc_we <= 1'b0;
    rd(core_state_pkg::SPACE_SFR, 16'h00e0, 8'h61);
    // ddc RAM through external moves and the post-incrementing window
    wr(core_state_pkg::SPACE_SFR, 16'h0096, 8'h01);
    wr(core_state_pkg::SPACE_XDATA, 16'hff10, 8'h5a);
    wr(core_state_pkg::SPACE_XDATA, 16'hff11, 8'ha5);
    rd(core_state_pkg::SPACE_XDATA, 16'hff10, 8'h5a);
    chk({15'h0, ddc_hit}, 16'h0001);
    wr(core_state_pkg::SPACE_SFR, 16'h0094, 8'h10);
    rd(core_state_pkg::SPACE_SFR, 16'h0095, 8'h5a);
    rd(core_state_pkg::SPACE_SFR, 16'h0095, 8'ha5);
    wr(core_state_pkg::SPACE_SFR, 16'h0096, 8'h00);
    rd(core_state_pkg::SPACE_XDATA, 16'hff10, 8'h00);
    chk({15'h0, ddc_hit}, 16'h0000);
    // flags: bank bits stay 10 while the alu and flag events act
    alu(1'b0, 8'h7f, 8'h01, 8'h55);
    @(posedge clk_sys);
    clear_range <= 1'b1;
    @(posedge clk_sys);
    clear_range <= 1'b0; bit_test <= 1'b1; bit_test_data <= 8'h40;
    #1 chk({8'h00, flags_out}, 16'h0051);
    @(posedge clk_sys);
    bit_test <= 1'b0;
    #1 chk({8'h00, flags_out}, 16'h0055);
    alu(1'b0, 8'hff, 8'h01, 8'hd0);
    @(posedge clk_sys);
    carry_we <= 1'b1; carry_in <= 1'b0;
    @(posedge clk_sys);
    carry_we <= 1'b0;
    #1 chk({8'h00, flags_out}, 16'h0050);
    // subtract: no borrow sets carry, nibble borrow clears it, sign overflow
    alu(1'b1, 8'h80, 8'h01, 8'h95);
    conclude();
  end
endmodule
